/* rtl/cds_regs.vh */
`ifndef CDS_REGS_VH
`define CDS_REGS_VH
// ----------------------------------------
// register addresses
// ----------------------------------------
`define CDS_ADDR_MISC_CONTROL_THREE 8'h21
`define CDS_ADDR_CLIP_DETECT_CTRL   8'h22
`define CDS_ADDR_CLIP_WINDOW_COUNT  8'h23
`define CDS_ADDR_CLIP_CHANNEL_FLAGS 8'h24
`define CDS_ADDR_CURRENT_LIMIT_FLAGS 8'h25
`define CDS_ADDR_MISC_CONTROL_FOUR  8'h26
`define CDS_ADDR_MISC_CONTROL_FIVE  8'h28
`define CDS_ADDR_SPREAD_ENABLE_CTRL 8'h77
`define CDS_ADDR_SPREAD_PREDIV_CTRL 8'h78
`define CDS_ADDR_SPREAD_STEP_CTRL   8'h79
// ----------------------------------------
// reset values
// ----------------------------------------
`define CDS_RST_MISC_CONTROL_THREE  8'h00
`define CDS_RST_CLIP_DETECT_CTRL    8'h01
`define CDS_RST_CLIP_WINDOW_COUNT   8'h14
`define CDS_RST_MISC_CONTROL_FOUR   8'h40
`define CDS_RST_MISC_CONTROL_FIVE   8'h0A
`define CDS_RST_SPREAD_ENABLE_CTRL  8'h00
`define CDS_RST_SPREAD_PREDIV_CTRL  8'h3F
`define CDS_RST_SPREAD_STEP_CTRL    8'h00
// ----------------------------------------
// field positions
// ----------------------------------------
`define CDS_BIT_CLIP_ENABLE         0
`define CDS_BIT_CLIP_LATCH_MODE     1
`define CDS_BIT_CLIP_PIN_ROUTE      2
`define CDS_BIT_CLEAR_FAULT         7
`define CDS_BIT_CLOCK_INVERT        3
`define CDS_HPF_MSB                 2
`define CDS_BIT_SPREAD_BW_SELECT    7
`define CDS_BIT_SPREAD_POST_DIV     6
`define CDS_BIT_PHASE_SELECT_MSB    5
`define CDS_BIT_SPREAD_ENABLE       7
`define CDS_PREDIV_MSB              6
`endif

/* rtl/cds_clip_counter.v */
`timescale 1ns/1ps
// ----------------------------------------
// per-channel full-duty run counter
// ----------------------------------------
module cds_clip_counter #(
  parameter WIDTH = 8
) (
  input  wire             clk_sys_i,
  input  wire             reset_n_i,
  input  wire             enable_i,
  input  wire             cycle_end_i,
  input  wire             full_duty_i,
  input  wire [WIDTH-1:0] window_i,
  output reg              clip_o
);
  reg [WIDTH-1:0] run_count;
  reg             enable_q;

  always @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      run_count <= {WIDTH{1'b0}};
      enable_q  <= 1'b0;
      clip_o    <= 1'b0;
    end else begin
      enable_q <= enable_i;
      if (!enable_i || !enable_q) begin
        // fresh start whenever detection is (re)enabled
        run_count <= {WIDTH{1'b0}};
        clip_o    <= 1'b0;
      end else if (cycle_end_i) begin
        if (!full_duty_i) begin
          run_count <= {WIDTH{1'b0}};
          clip_o    <= 1'b0;
        end else begin
          // saturate so a long clip never wraps back to idle
          if (run_count != {WIDTH{1'b1}})
            run_count <= run_count + 1'b1;
          if (run_count + 1'b1 >= window_i)
            clip_o <= 1'b1;
        end
      end
    end
  end
endmodule

/* rtl/cds_clip_spread_regs.v */
`timescale 1ns/1ps
`include "cds_regs.vh"
// Functional notes
// - clip detection runs only while enable set
// - latch bit 0 latches, 1 follows live
// - route bit 0 sends both channels to warning
// - clip after window count of full-duty cycles
// - read-only per-channel clip flags
// - read-only per-channel current-limit flags
// - clock-inversion bit marks inverted clock phase
// - three-bit highpass corner select, default zero
// - phase select msb from control five
// - spread enable bit turns modulation on
// - seven-bit pre-divider drives spread generator
// - eight-bit spread frequency step field
// - clear-fault write clears latched faults
module cds_clip_spread_regs #(
  parameter WINDOW_WIDTH = 8
) (
  input  wire       clk_sys_i,
  input  wire       reset_n_i,
  input  wire [7:0] reg_addr_i,
  input  wire [7:0] reg_wdata_i,
  input  wire       reg_write_i,
  output reg  [7:0] reg_rdata_o,
  input  wire [1:0] pwm_cycle_end_i,
  input  wire [1:0] pwm_full_duty_i,
  input  wire [1:0] current_limit_i,
  input  wire [1:0] phase_select_low_i,
  output wire       clip_warning_o,
  output wire       clip_warning_n_o,
  output wire       clear_fault_o,
  output wire       bit_clock_phase_invert_o,
  output wire [2:0] highpass_corner_select_o,
  output wire       spread_bandwidth_select_o,
  output wire       spread_post_divider_o,
  output wire [2:0] phase_select_o,
  output wire       spread_enable_o,
  output wire [6:0] spread_prediv_o,
  output wire [7:0] spread_step_o
);
  // ----------------------------------------
  // local constants
  // ----------------------------------------
  // only the three writable clip-control bits are stored
  localparam [7:0] CLIP_CTRL_RST = `CDS_RST_CLIP_DETECT_CTRL;

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  reg  [7:0] misc_control_three;
  reg  [2:0] clip_detect_ctrl;
  reg  [7:0] clip_window_count;
  reg  [7:0] misc_control_four;
  reg  [7:0] misc_control_five;
  reg  [7:0] spread_enable_ctrl;
  reg  [7:0] spread_prediv_ctrl;
  reg  [7:0] spread_step_ctrl;

  // ----------------------------------------
  // status and flag state
  // ----------------------------------------
  reg  [1:0] limit_meta;
  reg  [1:0] current_limit_flags;
  reg  [1:0] clip_latched;
  reg        warn_latched;
  reg  [1:0] next_clip_latched;
  reg        next_warn_latched;
  wire [1:0] clip_live;
  wire       clip_enable;
  wire       clip_latch_mode;
  wire       clear_fault_pulse;
  wire       warn_live;

  // ----------------------------------------
  // write decode
  // ----------------------------------------
  wire       wr_misc_three;
  wire       wr_clip_ctrl;
  wire       wr_clip_window;
  wire       wr_misc_four;
  wire       wr_misc_five;
  wire       wr_spread_enable;
  wire       wr_spread_prediv;
  wire       wr_spread_step;

  // status addresses get no select, so host writes there fall away
  assign wr_misc_three    = reg_write_i && (reg_addr_i == `CDS_ADDR_MISC_CONTROL_THREE);
  assign wr_clip_ctrl     = reg_write_i && (reg_addr_i == `CDS_ADDR_CLIP_DETECT_CTRL);
  assign wr_clip_window   = reg_write_i && (reg_addr_i == `CDS_ADDR_CLIP_WINDOW_COUNT);
  assign wr_misc_four     = reg_write_i && (reg_addr_i == `CDS_ADDR_MISC_CONTROL_FOUR);
  assign wr_misc_five     = reg_write_i && (reg_addr_i == `CDS_ADDR_MISC_CONTROL_FIVE);
  assign wr_spread_enable = reg_write_i && (reg_addr_i == `CDS_ADDR_SPREAD_ENABLE_CTRL);
  assign wr_spread_prediv = reg_write_i && (reg_addr_i == `CDS_ADDR_SPREAD_PREDIV_CTRL);
  assign wr_spread_step   = reg_write_i && (reg_addr_i == `CDS_ADDR_SPREAD_STEP_CTRL);

  assign clip_enable       = clip_detect_ctrl[`CDS_BIT_CLIP_ENABLE];
  assign clip_latch_mode   = clip_detect_ctrl[`CDS_BIT_CLIP_LATCH_MODE];
  assign clear_fault_pulse = wr_misc_three && reg_wdata_i[`CDS_BIT_CLEAR_FAULT];

  // ----------------------------------------
  // clear-fault register
  // ----------------------------------------
  always @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      misc_control_three <= `CDS_RST_MISC_CONTROL_THREE;
    end else if (wr_misc_three) begin
      misc_control_three <= reg_wdata_i;
    end
  end

  // ----------------------------------------
  // clip control and window
  // ----------------------------------------
  always @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      clip_detect_ctrl <= CLIP_CTRL_RST[2:0];
    end else if (wr_clip_ctrl) begin
      // reserved upper bits are dropped, so they read back as zero
      clip_detect_ctrl <= reg_wdata_i[2:0];
    end
  end

  always @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      clip_window_count <= `CDS_RST_CLIP_WINDOW_COUNT;
    end else if (wr_clip_window) begin
      clip_window_count <= reg_wdata_i;
    end
  end

  // ----------------------------------------
  // miscellaneous controls
  // ----------------------------------------
  always @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      misc_control_four <= `CDS_RST_MISC_CONTROL_FOUR;
    end else if (wr_misc_four) begin
      misc_control_four <= reg_wdata_i;
    end
  end

  always @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      misc_control_five <= `CDS_RST_MISC_CONTROL_FIVE;
    end else if (wr_misc_five) begin
      misc_control_five <= reg_wdata_i;
    end
  end

  // ----------------------------------------
  // spread-spectrum controls
  // ----------------------------------------
  always @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      spread_enable_ctrl <= `CDS_RST_SPREAD_ENABLE_CTRL;
    end else if (wr_spread_enable) begin
      spread_enable_ctrl <= reg_wdata_i;
    end
  end

  always @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      spread_prediv_ctrl <= `CDS_RST_SPREAD_PREDIV_CTRL;
    end else if (wr_spread_prediv) begin
      spread_prediv_ctrl <= reg_wdata_i;
    end
  end

  always @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      spread_step_ctrl <= `CDS_RST_SPREAD_STEP_CTRL;
    end else if (wr_spread_step) begin
      spread_step_ctrl <= reg_wdata_i;
    end
  end

  // ----------------------------------------
  // clip detection per channel
  // ----------------------------------------
  cds_clip_counter #(.WIDTH(WINDOW_WIDTH)) u_clip_ch1 (
    .clk_sys_i   (clk_sys_i),
    .reset_n_i   (reset_n_i),
    .enable_i    (clip_enable),
    .cycle_end_i (pwm_cycle_end_i[0]),
    .full_duty_i (pwm_full_duty_i[0]),
    .window_i    (clip_window_count[WINDOW_WIDTH-1:0]),
    .clip_o      (clip_live[0])
  );

  cds_clip_counter #(.WIDTH(WINDOW_WIDTH)) u_clip_ch2 (
    .clk_sys_i   (clk_sys_i),
    .reset_n_i   (reset_n_i),
    .enable_i    (clip_enable),
    .cycle_end_i (pwm_cycle_end_i[1]),
    .full_duty_i (pwm_full_duty_i[1]),
    .window_i    (clip_window_count[WINDOW_WIDTH-1:0]),
    .clip_o      (clip_live[1])
  );

  // ----------------------------------------
  // current-limit synchroniser
  // ----------------------------------------
  always @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      limit_meta          <= 2'h0;
      current_limit_flags <= 2'h0;
    end else begin
      // limit inputs come from the analog side, so synchronise them
      limit_meta          <= current_limit_i;
      current_limit_flags <= limit_meta;
    end
  end

  // ----------------------------------------
  // latched clip flags
  // ----------------------------------------
  // a new clip in the clear cycle wins over the clear
  always @* begin
    next_clip_latched = clip_latched;
    next_warn_latched = warn_latched;
    if (clear_fault_pulse) begin
      next_clip_latched = 2'h0;
      next_warn_latched = 1'b0;
    end
    next_clip_latched = next_clip_latched | clip_live;
    next_warn_latched = next_warn_latched | warn_live;
  end

  always @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      clip_latched <= 2'h0;
      warn_latched <= 1'b0;
    end else begin
      clip_latched <= next_clip_latched;
      warn_latched <= next_warn_latched;
    end
  end

  // ----------------------------------------
  // warning output and status views
  // ----------------------------------------
  wire [1:0] clip_flags_view;
  wire [1:0] limit_flags_view;

  // routing value 1 is reserved; both channels are reported either way
  assign warn_live        = |clip_live;
  assign clip_warning_o   = clip_latch_mode ? warn_live : warn_latched;
  assign clip_warning_n_o = ~clip_warning_o;
  assign clear_fault_o    = clear_fault_pulse;
  // flags follow the same latch choice as the warning pin
  assign clip_flags_view  = clip_latch_mode ? clip_live : clip_latched;
  assign limit_flags_view = current_limit_flags;

  // ----------------------------------------
  // outputs to the rest of the amplifier
  // ----------------------------------------
  wire       clock_invert_field;
  wire [2:0] corner_field;
  wire       bw_select_field;
  wire       post_div_field;
  wire       phase_msb_field;
  wire       spread_on_field;
  wire [6:0] prediv_field;
  wire [7:0] step_field;

  assign clock_invert_field = misc_control_four[`CDS_BIT_CLOCK_INVERT];
  assign corner_field       = misc_control_four[`CDS_HPF_MSB:0];
  assign bw_select_field    = misc_control_five[`CDS_BIT_SPREAD_BW_SELECT];
  assign post_div_field     = misc_control_five[`CDS_BIT_SPREAD_POST_DIV];
  assign phase_msb_field    = misc_control_five[`CDS_BIT_PHASE_SELECT_MSB];
  assign spread_on_field    = spread_enable_ctrl[`CDS_BIT_SPREAD_ENABLE];
  assign prediv_field       = spread_prediv_ctrl[`CDS_PREDIV_MSB:0];
  assign step_field         = spread_step_ctrl;

  // the pwm timing consumes these as plain levels
  assign bit_clock_phase_invert_o  = clock_invert_field;
  assign highpass_corner_select_o  = corner_field;
  assign spread_bandwidth_select_o = bw_select_field;
  assign spread_post_divider_o     = post_div_field;
  assign phase_select_o            = {phase_msb_field, phase_select_low_i};
  assign spread_enable_o           = spread_on_field;
  assign spread_prediv_o           = prediv_field;
  assign spread_step_o             = step_field;

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  always @* begin
    case (reg_addr_i)
      `CDS_ADDR_MISC_CONTROL_THREE: reg_rdata_o = misc_control_three;
      `CDS_ADDR_CLIP_DETECT_CTRL:   reg_rdata_o = {5'h00, clip_detect_ctrl};
      `CDS_ADDR_CLIP_WINDOW_COUNT:  reg_rdata_o = clip_window_count;
      `CDS_ADDR_CLIP_CHANNEL_FLAGS: reg_rdata_o = {6'h00, clip_flags_view};
      `CDS_ADDR_CURRENT_LIMIT_FLAGS: reg_rdata_o = {6'h00, limit_flags_view};
      `CDS_ADDR_MISC_CONTROL_FOUR:  reg_rdata_o = misc_control_four;
      `CDS_ADDR_MISC_CONTROL_FIVE:  reg_rdata_o = misc_control_five;
      `CDS_ADDR_SPREAD_ENABLE_CTRL: reg_rdata_o = spread_enable_ctrl;
      `CDS_ADDR_SPREAD_PREDIV_CTRL: reg_rdata_o = spread_prediv_ctrl;
      `CDS_ADDR_SPREAD_STEP_CTRL:   reg_rdata_o = spread_step_ctrl;
      default:                      reg_rdata_o = 8'h00;
    endcase
  end
endmodule

/* verification/cds_properties.sv */
`timescale 1ns/1ps
// ------------
// port checks
// ------------
module cds_checker (
  input wire       clk_sys_i,
  input wire       reset_n_i,
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire       reg_write_i,
  input wire [7:0] reg_rdata_o,
  input wire [1:0] phase_select_low_i,
  input wire       clip_warning_o,
  input wire       clip_warning_n_o,
  input wire       clear_fault_o,
  input wire [2:0] highpass_corner_select_o,
  input wire [2:0] phase_select_o,
  input wire       spread_enable_o,
  input wire [6:0] spread_prediv_o,
  input wire [7:0] spread_step_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  chk_clear_pulse: assert property (
    clear_fault_o == (reg_write_i && reg_addr_i == 8'h21 && reg_wdata_i[7]))
    else $error("clear pulse wrong");
  chk_warn_inverse: assert property (
    clip_warning_n_o == !clip_warning_o) else $error("warning pair mismatch");
  chk_warn_route: assert property (
    reg_addr_i == 8'h24 |-> clip_warning_o == (|reg_rdata_o[1:0]))
    else $error("warning not fed by both channel flags");
  chk_clip_upper: assert property (
    reg_addr_i == 8'h24 |-> reg_rdata_o[7:2] == 6'h00) else $error("clip flags upper set");
  chk_limit_upper: assert property (
    reg_addr_i == 8'h25 |-> reg_rdata_o[7:2] == 6'h00) else $error("limit flags upper set");
  chk_spread_write: assert property (
    reg_write_i && reg_addr_i == 8'h77 |=> spread_enable_o == $past(reg_wdata_i[7]))
    else $error("spread enable not taken");
  chk_prediv_write: assert property (
    reg_write_i && reg_addr_i == 8'h78 |=> spread_prediv_o == $past(reg_wdata_i[6:0]))
    else $error("prediv not taken");
  chk_step_write: assert property (
    reg_write_i && reg_addr_i == 8'h79 |=> spread_step_o == $past(reg_wdata_i))
    else $error("step not taken");
  chk_hpf_write: assert property (
    reg_write_i && reg_addr_i == 8'h26 |=> highpass_corner_select_o == $past(reg_wdata_i[2:0]))
    else $error("corner not taken");
  chk_phase_bits: assert property (
    reg_write_i && reg_addr_i == 8'h28 |=> phase_select_o == {$past(reg_wdata_i[5]),
    phase_select_low_i}) else $error("phase select wrong");
  chk_clip_off: assert property (
    reg_write_i && reg_addr_i == 8'h22 && reg_wdata_i[1:0] == 2'b10 |=> ##1 !clip_warning_o)
    else $error("warning after disable");
endmodule

/* verification/cds_host_model.sv */
`timescale 1ns/1ps
module cds_host_model (
  input  wire       clk_sys_i,
  input  wire [7:0] reg_rdata_i,
  output reg  [7:0] reg_addr_o,
  output reg  [7:0] reg_wdata_o,
  output reg        reg_write_o
);
  initial begin
    reg_addr_o = 8'h00;
    reg_wdata_o = 8'h00;
    reg_write_o = 1'b0;
  end
  // one-cycle strobe; stale data inverted so nothing leans on it
  task wr(input [7:0] a, input [7:0] v);
    begin
      @(negedge clk_sys_i);
      reg_addr_o = a;
      reg_wdata_o = v;
      reg_write_o = 1'b1;
      @(negedge clk_sys_i);
      reg_write_o = 1'b0;
      reg_wdata_o = ~v;
    end
  endtask
  task rd(input [7:0] a, output [7:0] v);
    begin
      @(negedge clk_sys_i);
      reg_addr_o = a;
      #10 v = reg_rdata_i;
    end
  endtask
  // bandwidth and post divider go up before the enable
  task spread_on(input [5:0] low);
    begin
      wr(8'h28, {2'b11, low});
      wr(8'h77, 8'h80);
    end
  endtask
endmodule

/* verification/clip_detect_and_spread_control_tb.sv */
`timescale 1ns/1ps
module clip_detect_and_spread_control_tb;
  reg        clk_sys_i;
  reg        reset_n_i;
  reg  [1:0] pwm_cycle_end_i;
  reg  [1:0] pwm_full_duty_i;
  reg  [1:0] current_limit_i;
  reg  [1:0] phase_select_low_i;
  wire [7:0] reg_addr_i;
  wire [7:0] reg_wdata_i;
  wire       reg_write_i;
  wire [7:0] reg_rdata_o;
  wire       clip_warning_o;
  wire       clip_warning_n_o;
  wire       clear_fault_o;
  wire       bit_clock_phase_invert_o;
  wire [2:0] highpass_corner_select_o;
  wire       spread_bandwidth_select_o;
  wire       spread_post_divider_o;
  wire [2:0] phase_select_o;
  wire       spread_enable_o;
  wire [6:0] spread_prediv_o;
  wire [7:0] spread_step_o;
  integer    n_mismatch;
  integer    num_checks;
  integer    i;
  reg  [7:0] d;
  // address, write data, expected read-back
  localparam logic [23:0] ROWS [8] = '{24'h230303, 24'h264D4D, 24'h785555, 24'h79A5A5,
    24'h22FB03, 24'h24FF00, 24'h25FF00, 24'h305A00};
  localparam logic [15:0] RSTV [10] = '{16'h2100, 16'h2201, 16'h2314, 16'h2400, 16'h2500,
    16'h2640, 16'h280A, 16'h7700, 16'h783F, 16'h7900};
  cds_clip_spread_regs DUT (.*);
  cds_host_model HOST (.clk_sys_i(clk_sys_i), .reg_rdata_i(reg_rdata_o),
    .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i), .reg_write_o(reg_write_i));
  initial begin
    clk_sys_i = 1'b0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end
  task chk(input [7:0] got, input [7:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task pulse(input [1:0] full, input integer n);
    integer k;
    begin
      for (k = 0; k < n; k = k + 1) begin
        @(negedge clk_sys_i);
        pwm_cycle_end_i = 2'b11;
        pwm_full_duty_i = full;
        @(negedge clk_sys_i);
        pwm_cycle_end_i = 2'b00;
      end
    end
  endtask
  task conclude;
    begin
      if (n_mismatch == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask
  // whole run is about a hundred cycles
  initial begin
    #200000;
    n_mismatch = n_mismatch + 1;
    conclude;
  end
  initial begin
    n_mismatch = 0;
    num_checks = 0;
    reset_n_i = 1'b0;
    pwm_cycle_end_i = 2'b00;
    pwm_full_duty_i = 2'b00;
    current_limit_i = 2'b00;
    phase_select_low_i = 2'b01;
    repeat (3) @(negedge clk_sys_i);
    reset_n_i = 1'b1;
    for (i = 0; i < 10; i = i + 1) begin
      HOST.rd(RSTV[i][15:8], d);
      chk(d, RSTV[i][7:0]);
    end
    for (i = 0; i < 8; i = i + 1) begin
      HOST.wr(ROWS[i][23:16], ROWS[i][15:8]);
      HOST.rd(ROWS[i][23:16], d);
      chk(d, ROWS[i][7:0]);
    end
    chk({7'h00, bit_clock_phase_invert_o}, 8'h01);
    for (i = 0; i < 8; i = i + 1) begin
      HOST.wr(8'h26, {5'h08, i[2:0]});
      chk({5'h00, highpass_corner_select_o}, i[7:0]);
    end
    pulse(2'b01, 2);
    chk({7'h00, clip_warning_o}, 8'h00);
    pulse(2'b01, 1);
    chk({7'h00, clip_warning_o}, 8'h01);
    HOST.rd(8'h24, d);
    chk(d, 8'h01);
    pulse(2'b00, 1);
    repeat (2) @(negedge clk_sys_i);
    chk({7'h00, clip_warning_o}, 8'h00);
    HOST.wr(8'h22, 8'h01);
    pulse(2'b10, 3);
    HOST.rd(8'h24, d);
    chk(d, 8'h03);
    pulse(2'b00, 2);
    chk({7'h00, clip_warning_o}, 8'h01);
    HOST.wr(8'h21, 8'h80);
    repeat (2) @(negedge clk_sys_i);
    chk({7'h00, clip_warning_o}, 8'h00);
    HOST.wr(8'h22, 8'h02);
    pulse(2'b11, 4);
    chk({6'h00, clip_warning_o, clip_warning_n_o}, 8'h01);
    current_limit_i = 2'b10;
    repeat (3) @(negedge clk_sys_i);
    HOST.rd(8'h25, d);
    chk(d, 8'h02);
    HOST.spread_on(6'h2A);
    chk({2'b00, spread_enable_o, spread_bandwidth_select_o, spread_post_divider_o,
      phase_select_o}, 8'h3D);
    reset_n_i = 1'b0;
    repeat (2) @(negedge clk_sys_i);
    reset_n_i = 1'b1;
    chk({7'h00, clip_warning_o}, 8'h00);
    HOST.rd(8'h22, d);
    chk(d, 8'h01);
    HOST.rd(8'h23, d);
    chk(d, 8'h14);
    HOST.rd(8'h77, d);
    chk(d, 8'h00);
    conclude;
  end
endmodule
bind cds_clip_spread_regs cds_checker CHK (.*);
